// [design/cic_pkg.sv]
package cic_pkg;
    // ************************************
    // Port map and widths
    // ************************************
    localparam int ADDR_W = 16;
    localparam int LINES = 8;
    localparam logic [15:0] M_CMD = 16'h0020;
    localparam logic [15:0] M_DAT = 16'h0021;
    localparam logic [15:0] S_CMD = 16'h00a0;
    localparam logic [15:0] S_DAT = 16'h00a1;
    localparam int MASTER = 0;
    localparam int SLAVE = 1;
    // ************************************
    // Command word fields
    // ************************************
    localparam int INIT_WORD_FIRST_BIT = 4;
    localparam int OP_WORD_READ_POLL_BIT = 3;
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 5;
    localparam int ESMM_BIT = 6;
    localparam int SMM_BIT = 5;
    localparam int POLL_BIT = 2;
    localparam int RR_BIT = 1;
    localparam int RIS_BIT = 0;
    localparam int AUTO_END_OF_INTERRUPT_BIT = 1;
    localparam int SFNM_BIT = 4;
    localparam int VEC_LSB = 3;
    localparam int POLL_VALID_BIT = 7;
    localparam logic [2:0] LOWEST_RST = 3'h7;
    localparam logic [2:0] SPUR_LVL = 3'h7;
    localparam logic [7:0] ZERO8 = 8'h00;
    // Priority and end-of-interrupt commands, as {rotate, select, end}
    localparam logic [2:0] OP_NS_EOI = 3'h1;
    localparam logic [2:0] OP_SP_EOI = 3'h3;
    localparam logic [2:0] OP_ROT_NS = 3'h5;
    localparam logic [2:0] OP_ROT_SP = 3'h7;
    localparam logic [2:0] OP_SET_PRI = 3'h6;
    localparam logic [2:0] OP_RAEOI_SET = 3'h4;
    localparam logic [2:0] OP_RAEOI_CLR = 3'h0;
    // Initialization sequence states
    typedef enum logic [1:0] {
        CIC_READY = 2'b00,
        CIC_W_VEC = 2'b01,
        CIC_W_CAS = 2'b10,
        CIC_W_MODE = 2'b11
    } cic_init_t;
endpackage

// [design/cic_prio.sv]
`timescale 1ns/1ps
module cic_prio
(
    // Request state
    input wire logic [cic_pkg::LINES-1:0] i_req,
    input wire logic [cic_pkg::LINES-1:0] i_block,
    input wire logic [cic_pkg::LINES-1:0] i_mask,
    input wire logic [cic_pkg::LINES-1:0] i_eoi_cand,
    input wire logic [2:0] i_lowest,
    // Results
    output logic o_valid,
    output logic [2:0] o_level,
    output logic o_top_valid,
    output logic [2:0] o_top_level
);
    import cic_pkg::*;

    // Level holding rank k, counted from the highest priority
    function automatic logic [2:0] rank_lvl(input logic [2:0] low, input logic [2:0] k);
        rank_lvl = 3'(low + 3'h1 + k);
    endfunction

    // ************************************
    // Winner search in rotated order
    // ************************************
    always_comb
    begin
        logic stop;
        logic [2:0] lvl;
        stop = 1'b0;
        lvl = 3'h0;
        o_valid = 1'b0;
        o_level = 3'h0;
        for (int k = 0; k < LINES; k++)
        begin
            lvl = rank_lvl(i_lowest, 3'(k));
            if (!stop)
            begin
                if (i_block[lvl])
                    stop = 1'b1; // In service: same and lower wait
                else if (i_req[lvl] && !i_mask[lvl])
                begin
                    o_valid = 1'b1;
                    o_level = lvl;
                    stop = 1'b1;
                end
            end
        end
    end

    // Highest in-service level eligible for a non-specific end
    always_comb
    begin
        logic hit;
        logic [2:0] lvl;
        hit = 1'b0;
        lvl = 3'h0;
        o_top_level = 3'h0;
        for (int k = 0; k < LINES; k++)
        begin
            lvl = rank_lvl(i_lowest, 3'(k));
            if (!hit && i_eoi_cand[lvl])
            begin
                hit = 1'b1;
                o_top_level = lvl;
            end
        end
        o_top_valid = hit;
    end
endmodule // cic_prio

// [design/cic_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - Base port write with data bit 4 set starts initialization.
// - Next three base+1 writes are vector, cascade and mode words in order.
// - Slave drives vector on second pulse only if cascade code matches its ID.
// - Mask word: 1 blocks the matching request line, 0 lets it through.
// - Operation words accepted any time after initialization completes.
// - Non-specific end clears the highest-priority in-service bit.
// - Specific end clears the in-service bit named by the level field.
// - In special mask mode non-specific end skips masked in-service bits.
// - Auto end performs non-specific end at trailing edge of last pulse.
// - Fully nested: level 0 highest; in-service blocks same and lower levels.
// - Special fully nested master does not lock out an in-service slave.
// - Rotation makes serviced level lowest; rotate-in-auto-end set and cleared.
// - Set-priority makes given level lowest without any end action.
// - Rotate-on-specific-end clears given level and makes it lowest.
// - Poll: next read acts as acknowledge, returns level; requests frozen meanwhile.
// - Master drives its winning cascade line number, 010, to select the slave.
// - Special mask set by enable and mode flags 1, cleared by enable 1, mode 0.
// - Command port reads request register, or in-service register when selected.
module cic_top
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Host I/O port
    input wire logic [cic_pkg::ADDR_W-1:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    output logic o_io_rdata_valid,
    // Interrupt acknowledge and request to processor
    input wire logic i_acknowledge_strobe_n,
    output logic [7:0] o_ack_vector,
    output logic o_ack_vector_valid,
    output logic o_interrupt_output,
    output logic [2:0] o_cascade_code,
    // Request lines, 7:0 master except line 2 (fed by the slave), and 15:8 slave
    input wire logic [2*cic_pkg::LINES-1:0] i_irq
);
    import cic_pkg::*;

    function automatic logic [7:0] onehot(input logic [2:0] lvl);
        onehot = 8'h01 << lvl;
    endfunction

    function automatic logic [15:0] port_addr(input int c, input logic dat);
        if (c == MASTER)
            port_addr = dat ? M_DAT : M_CMD;
        else
            port_addr = dat ? S_DAT : S_CMD;
    endfunction

    // ************************************
    // Shared acknowledge sequencing
    // ************************************
    logic ack_q;
    logic ack_second;
    logic casc_sel;
    logic ack_fall;
    logic ack_rise;
    logic ack_last;
    logic ack_end;
    logic take_first;
    logic take [2];
    logic ex_int [2];
    logic ex_hit [2];
    logic [2:0] ex_level [2];
    logic [2:0] ex_id [2];
    logic [7:0] ex_vec [2];
    logic ex_rd [2];
    logic [7:0] ex_rdata [2];
    logic [7:0] m_in;

    assign ack_fall = ack_q && !i_acknowledge_strobe_n;
    assign ack_rise = !ack_q && i_acknowledge_strobe_n;
    // Sequence ends only when the second pulse rises
    assign ack_end = ack_rise && ack_last;
    assign take_first = ack_fall && !ack_second;
    assign take[MASTER] = take_first;
    assign take[SLAVE] = take_first && ex_hit[MASTER];
    // Slave request feeds master cascade line
    assign m_in = {i_irq[7:3], ex_int[SLAVE], i_irq[1:0]};

    // Two-pulse tracking
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ack_q <= 1'b1;
            ack_second <= 1'b0;
            ack_last <= 1'b0;
        end
        else
        begin
            ack_q <= i_acknowledge_strobe_n;
            if (ack_end)
                ack_second <= 1'b0;
            else if (take_first)
                ack_second <= 1'b1;
            if (ack_end)
                ack_last <= 1'b0;
            else if (ack_fall && ack_second)
                ack_last <= 1'b1; // Second pulse seen
        end
    end

    // Cascade bus, driven with the master's winning line when it is a cascade line, else 0
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            casc_sel <= 1'b0;
            o_cascade_code <= 3'h0;
        end
        else if (take_first)
        begin
            casc_sel <= ex_hit[MASTER];
            o_cascade_code <= ex_hit[MASTER] ? ex_level[MASTER] : 3'h0;
        end
        else if (ack_end)
        begin
            casc_sel <= 1'b0;
            o_cascade_code <= 3'h0;
        end
    end

    // Vector on second pulse, from slave only on identity match
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_ack_vector <= ZERO8;
            o_ack_vector_valid <= 1'b0;
        end
        else if (ack_fall && ack_second)
        begin
            if (casc_sel && o_cascade_code == ex_id[SLAVE])
            begin
                o_ack_vector <= ex_vec[SLAVE];
                o_ack_vector_valid <= 1'b1;
            end
            else if (!casc_sel)
            begin
                o_ack_vector <= ex_vec[MASTER];
                o_ack_vector_valid <= 1'b1;
            end
        end
        else if (ack_rise)
            o_ack_vector_valid <= 1'b0;
    end

    // Request to processor and host read data
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_interrupt_output <= 1'b0;
            o_io_rdata <= ZERO8;
            o_io_rdata_valid <= 1'b0;
        end
        else
        begin
            o_interrupt_output <= ex_int[MASTER];
            o_io_rdata_valid <= ex_rd[MASTER] || ex_rd[SLAVE];
            o_io_rdata <= ex_rd[SLAVE] ? ex_rdata[SLAVE] : ex_rdata[MASTER];
        end
    end

    // ************************************
    // Per-controller core
    // ************************************
    for (genvar c = 0; c < 2; c++)
    begin : g_ctl
        cic_init_t state;
        logic done;
        logic [4:0] vec_base;
        logic [7:0] cas_word;
        logic [7:0] mode_word;
        logic [7:0] request_register;
        logic [7:0] in_service_register;
        logic [7:0] mask_register;
        logic [7:0] irq_q;
        logic [7:0] in_lv;
        logic [7:0] lvl_sel;
        logic [2:0] lowest;
        logic [2:0] ack_level;
        logic rot_auto_end_of_interrupt;
        logic special_mask_flag;
        logic read_isr;
        logic poll;
        logic took;
        logic res_valid;
        logic [2:0] res_level;
        logic top_valid;
        logic [2:0] top_level;
        logic cmd_wr;
        logic dat_wr;
        logic rd_any;
        logic init_word_first_wr;
        logic op_word_priority_eoi_wr;
        logic op_word_read_poll_wr;
        logic poll_take;
        logic auto_end_of_interrupt_end;
        logic [2:0] op;
        logic [2:0] wlvl;
        logic [7:0] next_irr;
        logic [7:0] next_isr;
        logic [2:0] next_lowest;
        logic [7:0] blk;

        assign in_lv = (c == MASTER) ? m_in : i_irq[15:8];
        assign lvl_sel = (c == MASTER) ? cas_word : ZERO8;
        assign cmd_wr = i_io_wr && i_io_addr == port_addr(c, 1'b0);
        assign dat_wr = i_io_wr && i_io_addr == port_addr(c, 1'b1);
        assign rd_any = i_io_rd && (i_io_addr == port_addr(c, 1'b0)
            || i_io_addr == port_addr(c, 1'b1));
        assign init_word_first_wr = cmd_wr && i_io_wdata[INIT_WORD_FIRST_BIT];
        assign op_word_priority_eoi_wr = cmd_wr && done && !i_io_wdata[INIT_WORD_FIRST_BIT]
            && !i_io_wdata[OP_WORD_READ_POLL_BIT];
        assign op_word_read_poll_wr = cmd_wr && done && !i_io_wdata[INIT_WORD_FIRST_BIT]
            && i_io_wdata[OP_WORD_READ_POLL_BIT];
        assign op = i_io_wdata[CMD_MSB:CMD_LSB];
        assign wlvl = i_io_wdata[2:0];
        assign poll_take = rd_any && poll;
        assign auto_end_of_interrupt_end = ack_end && took && mode_word[AUTO_END_OF_INTERRUPT_BIT];
        // In-service blocking; special fully nested frees the cascade line
        assign blk = special_mask_flag ? ZERO8
            : (in_service_register & ~((c == MASTER && mode_word[SFNM_BIT]) ? cas_word : ZERO8));

        cic_prio u_prio
        (
            .i_req(request_register),
            .i_block(blk),
            .i_mask(mask_register),
            .i_eoi_cand(in_service_register & ~(special_mask_flag ? mask_register : ZERO8)),
            .i_lowest(lowest),
            .o_valid(res_valid),
            .o_level(res_level),
            .o_top_valid(top_valid),
            .o_top_level(top_level)
        );

        assign ex_int[c] = res_valid && done && !poll;
        assign ex_hit[c] = res_valid && cas_word[res_level];
        assign ex_level[c] = res_level;
        assign ex_id[c] = cas_word[2:0];
        assign ex_vec[c] = {vec_base, ack_level};
        assign ex_rd[c] = rd_any;

        // Read data: poll result, mask on data port, else in-service or request
        always_comb
        begin
            if (poll)
                ex_rdata[c] = {res_valid, 4'h0, res_level};
            else if (i_io_addr == port_addr(c, 1'b1))
                ex_rdata[c] = mask_register;
            else
                ex_rdata[c] = read_isr ? in_service_register : request_register;
        end

        // Requests: edge lines latch, cascade line follows level, poll freezes
        always_comb
        begin
            next_irr = request_register;
            if ((take[c] || poll_take) && res_valid)
                next_irr[res_level] = 1'b0;
            if (!poll)
                next_irr = (next_irr & ~lvl_sel) | (in_lv & ~irq_q & ~lvl_sel)
                    | (in_lv & lvl_sel);
        end

        // In-service update: set by acknowledge, cleared by end commands
        always_comb
        begin
            next_isr = in_service_register;
            if (auto_end_of_interrupt_end && top_valid)
                next_isr[top_level] = 1'b0;
            if (op_word_priority_eoi_wr)
            begin
                if ((op == OP_NS_EOI || op == OP_ROT_NS) && top_valid)
                    next_isr = next_isr & ~onehot(top_level);
                else if (op == OP_SP_EOI || op == OP_ROT_SP)
                    next_isr = next_isr & ~onehot(wlvl);
            end
            if ((take[c] || poll_take) && res_valid)
                next_isr[res_level] = 1'b1;
            if (init_word_first_wr)
                next_isr = ZERO8;
        end

        // Lowest-priority pointer for rotation
        always_comb
        begin
            next_lowest = lowest;
            if (auto_end_of_interrupt_end && rot_auto_end_of_interrupt && top_valid)
                next_lowest = top_level;
            if (op_word_priority_eoi_wr)
            begin
                if (op == OP_ROT_NS && top_valid)
                    next_lowest = top_level;
                else if (op == OP_SET_PRI || op == OP_ROT_SP)
                    next_lowest = wlvl;
            end
            if (init_word_first_wr)
                next_lowest = LOWEST_RST;
        end

        // Request, in-service and priority registers
        always_ff @(posedge i_clk)
        begin
            if (i_rst)
            begin
                request_register <= ZERO8;
                in_service_register <= ZERO8;
                irq_q <= ZERO8;
                lowest <= LOWEST_RST;
            end
            else
            begin
                irq_q <= in_lv;
                request_register <= next_irr;
                in_service_register <= next_isr;
                lowest <= next_lowest;
            end
        end

        // Acknowledge capture per controller
        always_ff @(posedge i_clk)
        begin
            if (i_rst)
            begin
                ack_level <= SPUR_LVL;
                took <= 1'b0;
            end
            else if (take[c])
            begin
                ack_level <= res_valid ? res_level : SPUR_LVL;
                took <= res_valid;
            end
            else if (ack_end)
                took <= 1'b0;
        end

        // Initialization sequence and mask
        always_ff @(posedge i_clk)
        begin
            if (i_rst)
            begin
                state <= CIC_READY;
                done <= 1'b0;
                vec_base <= 5'h00;
                cas_word <= ZERO8;
                mode_word <= ZERO8;
                mask_register <= ZERO8;
            end
            else if (init_word_first_wr)
            begin
                state <= CIC_W_VEC;
                done <= 1'b0;
                mask_register <= ZERO8;
            end
            else if (dat_wr)
            begin
                case (state)
                    CIC_W_VEC:
                    begin
                        vec_base <= i_io_wdata[7:VEC_LSB];
                        state <= CIC_W_CAS;
                    end
                    CIC_W_CAS:
                    begin
                        cas_word <= i_io_wdata;
                        state <= CIC_W_MODE;
                    end
                    CIC_W_MODE:
                    begin
                        mode_word <= i_io_wdata;
                        state <= CIC_READY;
                        done <= 1'b1;
                    end
                    default:
                    begin
                        if (done)
                            mask_register <= i_io_wdata;
                    end
                endcase
            end
        end

        // Operation modes: rotation, special mask, read select, poll
        always_ff @(posedge i_clk)
        begin
            if (i_rst || init_word_first_wr)
            begin
                rot_auto_end_of_interrupt <= 1'b0;
                special_mask_flag <= 1'b0;
                read_isr <= 1'b0;
                poll <= 1'b0;
            end
            else
            begin
                if (op_word_priority_eoi_wr && op == OP_RAEOI_SET)
                    rot_auto_end_of_interrupt <= 1'b1;
                else if (op_word_priority_eoi_wr && op == OP_RAEOI_CLR)
                    rot_auto_end_of_interrupt <= 1'b0;
                if (op_word_read_poll_wr && i_io_wdata[ESMM_BIT])
                    special_mask_flag <= i_io_wdata[SMM_BIT];
                if (op_word_read_poll_wr && i_io_wdata[RR_BIT])
                    read_isr <= i_io_wdata[RIS_BIT];
                if (op_word_read_poll_wr && i_io_wdata[POLL_BIT])
                    poll <= 1'b1;
                else if (poll_take)
                    poll <= 1'b0;
            end
        end
    end

    // ************************************
    // Assertions
    // ************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_init_word_first_start;
        g_ctl[0].init_word_first_wr |=> g_ctl[0].state == CIC_W_VEC && !g_ctl[0].done;
    endproperty
    a_init_word_first_start: assert property (p_init_word_first_start) else $error("init start missed");

    property p_init_order;
        $rose(g_ctl[1].done) |-> $past(g_ctl[1].state) == CIC_W_MODE && $past(g_ctl[1].dat_wr);
    endproperty
    a_init_order: assert property (p_init_order) else $error("init order broken");

    property p_slave_vec;
        ack_fall && ack_second && casc_sel && o_cascade_code == g_ctl[1].cas_word[2:0]
            |=> o_ack_vector_valid && o_ack_vector == {g_ctl[1].vec_base, g_ctl[1].ack_level};
    endproperty
    a_slave_vec: assert property (p_slave_vec) else $error("slave vector wrong");

    property p_mask_load;
        g_ctl[0].dat_wr && g_ctl[0].done && g_ctl[0].state == CIC_READY
            |=> g_ctl[0].mask_register == $past(i_io_wdata);
    endproperty
    a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

    property p_ns_eoi;
        g_ctl[0].op_word_priority_eoi_wr && g_ctl[0].op == OP_NS_EOI && g_ctl[0].top_valid
            && !take_first && !g_ctl[0].poll_take
            |=> !g_ctl[0].in_service_register[$past(g_ctl[0].top_level)];
    endproperty
    a_ns_eoi: assert property (p_ns_eoi) else $error("eoi did not clear");

    property p_ack_sets;
        take_first && g_ctl[0].res_valid && !g_ctl[0].init_word_first_wr
            |=> g_ctl[0].in_service_register[$past(g_ctl[0].res_level)];
    endproperty
    a_ack_sets: assert property (p_ack_sets) else $error("in-service not set");

    property p_set_prio;
        g_ctl[1].op_word_priority_eoi_wr && g_ctl[1].op == OP_SET_PRI ##1 !g_ctl[1].op_word_priority_eoi_wr [*2]
            |-> g_ctl[1].lowest == $past(i_io_wdata[2:0], 2) || $past(g_ctl[1].auto_end_of_interrupt_end)
            || $past(g_ctl[1].init_word_first_wr);
    endproperty
    a_set_prio: assert property (p_set_prio) else $error("priority not set");

    property p_casc_code;
        $rose(casc_sel) |-> g_ctl[0].cas_word[o_cascade_code] ##1 casc_sel [*1];
    endproperty
    a_casc_code: assert property (p_casc_code) else $error("bad cascade code");

    property p_poll_read;
        g_ctl[0].poll_take && g_ctl[0].res_valid && !ex_rd[1]
            |=> o_io_rdata_valid && o_io_rdata[POLL_VALID_BIT];
    endproperty
    a_poll_read: assert property (p_poll_read) else $error("poll result wrong");

    c_slave_ack: cover property (casc_sel ##[1:20] o_ack_vector_valid);
    c_master_ack: cover property (!casc_sel && o_ack_vector_valid);
    c_poll: cover property (g_ctl[0].poll_take && g_ctl[0].res_valid);
    c_rotate: cover property (g_ctl[0].op_word_priority_eoi_wr && g_ctl[0].op == OP_ROT_SP);
endmodule // cic_top

// [verif/cic_host.sv]
`timescale 1ns/1ps
module cic_host
(
    // Clock
    input wire logic i_clk,
    // Answers from the controller
    input wire logic [7:0] i_io_rdata,
    input wire logic i_io_rdata_valid,
    input wire logic [7:0] i_ack_vector,
    input wire logic i_ack_vector_valid,
    // Requests to the controller
    output logic [cic_pkg::ADDR_W-1:0] o_io_addr,
    output logic o_io_wr,
    output logic o_io_rd,
    output logic [7:0] o_io_wdata,
    output logic o_acknowledge_strobe_n
);
    import cic_pkg::*;
    // Idle levels at time zero
    initial
    begin
        o_io_addr = 16'h0000;
        o_io_wr = 1'b0;
        o_io_rd = 1'b0;
        o_io_wdata = 8'h00;
        o_acknowledge_strobe_n = 1'b1;
    end
    // One write; data bus shows the inverse once released
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_io_addr = a;
        o_io_wdata = d;
        o_io_wr = 1'b1;
        @(negedge i_clk);
        o_io_wr = 1'b0;
        o_io_wdata = ~d;
    endtask
    // One read; unknown comes back when no valid pulse shows
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_io_addr = a;
        o_io_rd = 1'b1;
        @(negedge i_clk);
        d = i_io_rdata_valid ? i_io_rdata : 8'hxx;
        o_io_rd = 1'b0;
    endtask
    // Four-word setup of one controller
    task automatic init(input logic [15:0] base, input logic [7:0] vec, input logic [7:0] cas);
        wr(base, 8'h11);
        wr(base + 16'h0001, vec);
        wr(base + 16'h0001, cas);
        wr(base + 16'h0001, 8'h01);
    endtask
    // Two-pulse acknowledge; vector taken while second pulse is low
    task automatic ack(output logic [7:0] v);
        @(negedge i_clk);
        o_acknowledge_strobe_n = 1'b0;
        repeat (2) @(negedge i_clk);
        o_acknowledge_strobe_n = 1'b1;
        repeat (2) @(negedge i_clk);
        o_acknowledge_strobe_n = 1'b0;
        repeat (2) @(negedge i_clk);
        v = i_ack_vector_valid ? i_ack_vector : 8'hxx;
        o_acknowledge_strobe_n = 1'b1;
    endtask
    // End of a slave-routed service goes to both controllers
    task automatic eoi_both();
        wr(S_CMD, 8'h20);
        wr(M_CMD, 8'h20);
    endtask
endmodule // cic_host

// [verif/cic_top_tb.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module cic_top_tb;
    import cic_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] i_irq = 16'h0000;
    logic [15:0] io_addr;
    logic io_wr, io_rd, ack_n, rvalid, vvalid, irq_out;
    logic [7:0] wdata, rdata, vec, d;
    logic [2:0] cas;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    // Clock, timeout guard
    initial
    begin
        forever #2.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end
    cic_top u_cic_top (.i_clk(i_clk), .i_rst(i_rst), .i_io_addr(io_addr), .i_io_wr(io_wr),
        .i_io_rd(io_rd), .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_rdata_valid(rvalid),
        .i_acknowledge_strobe_n(ack_n), .o_ack_vector(vec), .o_ack_vector_valid(vvalid),
        .o_interrupt_output(irq_out), .o_cascade_code(cas), .i_irq(i_irq));
    cic_host u_cic_host (.i_clk(i_clk), .i_io_rdata(rdata), .i_io_rdata_valid(rvalid),
        .i_ack_vector(vec), .i_ack_vector_valid(vvalid), .o_io_addr(io_addr),
        .o_io_wr(io_wr), .o_io_rd(io_rd), .o_io_wdata(wdata), .o_acknowledge_strobe_n(ack_n));
    // Raise one request line and let it settle
    task automatic raise(input int n);
        @(negedge i_clk);
        i_irq[n] = 1'b1;
        repeat (4) @(negedge i_clk);
    endtask
    // Mask holds off a request; unmasking lets it through
    task automatic t_mask();
        u_cic_host.wr(M_DAT, 8'h08);
        raise(3);
        `CHK(irq_out, 1'b0)
        u_cic_host.rd(M_DAT, d);
        `CHK(d, 8'h08)
        u_cic_host.rd(M_CMD, d);
        `CHK(d, 8'h08)
        u_cic_host.wr(M_DAT, 8'h00);
        repeat (3) @(negedge i_clk);
        `CHK(irq_out, 1'b1)
        u_cic_host.ack(d);
        `CHK(d, 8'h23)
    endtask
    // Nesting, then non-specific and specific end
    task automatic t_nest();
        raise(5);
        `CHK(irq_out, 1'b0)
        raise(1);
        `CHK(irq_out, 1'b1)
        u_cic_host.ack(d);
        `CHK(d, 8'h21)
        u_cic_host.wr(M_CMD, 8'h0b);
        u_cic_host.rd(M_CMD, d);
        `CHK(d, 8'h0a)
        u_cic_host.wr(M_CMD, 8'h20);
        u_cic_host.rd(M_CMD, d);
        `CHK(d, 8'h08)
        u_cic_host.wr(M_CMD, 8'h63);
        u_cic_host.rd(M_CMD, d);
        `CHK(d, 8'h00)
        u_cic_host.ack(d);
        `CHK(d, 8'h25)
        u_cic_host.wr(M_CMD, 8'h65);
        i_irq = 16'h0000;
    endtask
    // Poll read acts as acknowledge and returns the level
    task automatic t_poll();
        raise(6);
        u_cic_host.wr(M_CMD, 8'h0c);
        u_cic_host.rd(M_CMD, d);
        `CHK(d, 8'h86)
        u_cic_host.rd(M_CMD, d);
        `CHK(d, 8'h40)
        u_cic_host.wr(M_CMD, 8'h20);
    endtask
    // Set priority on the slave lets level 4 beat level 1
    task automatic t_rotate();
        i_irq = 16'h0000;
        u_cic_host.wr(S_CMD, 8'hc3);
        raise(9);
        raise(12);
        u_cic_host.ack(d);
        `CHK(d, 8'h2c)
        u_cic_host.eoi_both();
    endtask
    // Slave request routed through the cascade line
    task automatic t_slave();
        raise(9);
        `CHK(irq_out, 1'b1)
        u_cic_host.ack(d);
        `CHK(d, 8'h29)
        u_cic_host.eoi_both();
        u_cic_host.rd(M_CMD, d);
        `CHK(d, 8'h00)
    endtask
    // Closing report
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(negedge i_clk);
        i_rst = 1'b0;
        u_cic_host.init(M_CMD, 8'h20, 8'h04);
        u_cic_host.init(S_CMD, 8'h28, 8'h02);
        t_mask();
        t_nest();
        t_poll();
        t_slave();
        t_rotate();
        end_sim();
    end
endmodule // cic_top_tb
